// *** bench/cmd_ctrl_model.sv ***
/*
  Controller model: replays queued command-bus cycles, else deselect.
  Assumes the bench queues whole command pairs, apart from one lone write first half.
*/
`timescale 1ns/10ps
module cmd_ctrl_model
(
  input wire logic core_clk,
  output cmd_decoder_pkg::cmd_bus_type bus_out
);
  import cmd_decoder_pkg::*;
  cmd_bus_type q[$];  // Cycles waiting, one per falling edge
  // Queued cycles leave back to back in queue order, legal or not; one process drives the bus
  initial
  begin
    bus_out = '0;
    forever
    begin
      @(negedge core_clk);
      if (q.size() != 0)
        bus_out <= q.pop_front();
      else
        // Idle lines float: toggled so stale values never match
        bus_out <= {1'b0, ~bus_out.cmd_addr_lines};
    end
  end
endmodule : cmd_ctrl_model

// *** bench/cmd_decoder_chk.sv ***
/*
  Port assertions for the command decoder.
  Assumes one clock and an async active-high reset.
*/
`timescale 1ns/10ps
`include "cmd_decoder_regs.svh"
module cmd_decoder_chk
(
  input wire logic core_clk,
  input wire logic rst,
  input cmd_decoder_pkg::cmd_bus_type bus_in,
  input wire logic burst_on_the_fly,
  input cmd_decoder_pkg::cmd_out_type cmd_out_ff,
  input wire logic cmd_valid_ff,
  input wire logic order_error_ff
);
  import cmd_decoder_pkg::*;
  wire logic cs = bus_in.cs;  // Chip select
  wire logic [5:0] ln = bus_in.cmd_addr_lines;  // Line shorthand
  logic sec_ff;  // Cycle owed to a second half
  logic nxt_sec;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A taken first half owns the next cycle
  always_comb nxt_sec = cs && !sec_ff;
  // Slot register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sec_ff <= 1'b0;
    else
      sec_ff <= nxt_sec;
  end
  // Clean first half; errors excluded since later decode is unspecified
  sequence s_first(logic [4:0] c);
    cs && !sec_ff && !order_error_ff && ln[4:0] == c;
  endsequence
  sequence s_pair(logic [4:0] c);
    s_first(c) ##1 !cs;
  endsequence
  property p_bank(logic [4:0] c, op_type o);
    s_pair(c) |=> cmd_valid_ff && cmd_out_ff.op == o
      && cmd_out_ff.all_banks_flag == $past(ln[5], 2)
      && cmd_out_ff.bank == ($past(ln[5], 2) ? 3'h0 : $past(ln[2:0]));
  endproperty
  // Access pair then column pair; fields from one to four cycles back
  property p_access(logic [4:0] c, op_type o);
    s_pair(c) ##1 s_pair(`OPC_COLUMN_SECOND) |=> cmd_valid_ff && cmd_out_ff.op == o
      && cmd_out_ff.auto_close_flag == $past(ln[5], 3)
      && cmd_out_ff.column == {$past(ln[4], 3), $past(ln[5], 2), $past(ln), 2'b00}
      && cmd_out_ff.burst_len_select == (($past(burst_on_the_fly, 4) && $past(ln[5], 4))
      ? `BURST_LONG : `BURST_SHORT);
  endproperty
  chk_valid_gap: assert property (cmd_valid_ff |=> !cmd_valid_ff)
    else $error("valid lasted two cycles");
  chk_precharge_dec: assert property (p_bank(`OPC_PRECHARGE, op_precharge))
    else $error("precharge decode wrong");
  chk_refresh_dec: assert property (p_bank(`OPC_REFRESH, op_refresh))
    else $error("refresh decode wrong");
  chk_multi_dec: assert property (s_first(`OPC_MULTI) ##0 !ln[5] ##1 !cs && ln != 6'h07
    |=> cmd_valid_ff && cmd_out_ff.op == op_multi
    && cmd_out_ff.operand[6:0] == {1'b0, $past(ln)})
    else $error("multipurpose decode wrong");
  chk_read_fields: assert property (p_access(`OPC_READ, op_read))
    else $error("read fields wrong");
  chk_write_fields: assert property (p_access(`OPC_WRITE, op_write))
    else $error("write fields wrong");
  chk_reserved_refused: assert property (cs && !sec_ff
    && ln[4:0] inside {5'h1c, 5'h0a, 5'h1a, 5'h1e} |-> ##2 order_error_ff && !cmd_valid_ff)
    else $error("reserved code not refused");
  chk_pair_break: assert property (s_pair(`OPC_WRITE) ##1 !cs |-> ##[1:2] order_error_ff)
    else $error("broken pair not flagged");
endmodule : cmd_decoder_chk

bind dram_two_cycle_command_decoder cmd_decoder_chk u_chk (.core_clk(core_clk), .rst(rst),
  .bus_in(bus_in), .burst_on_the_fly(burst_on_the_fly), .cmd_out_ff(cmd_out_ff),
  .cmd_valid_ff(cmd_valid_ff), .order_error_ff(order_error_ff));

// *** bench/dram_two_cycle_command_decoder_test.sv ***
/*
  Bench: queues command pairs into the controller model, checks decode.
  Assumes the checker is bound to the decoder.
*/
`timescale 1ns/10ps
`include "cmd_decoder_regs.svh"
module dram_two_cycle_command_decoder_test;
  import cmd_decoder_pkg::*;
  logic core_clk = 1'b0;  // 100 MHz
  logic rst = 1'b1;  // Held from time zero
  logic burst_on_the_fly = 1'b0;
  cmd_bus_type bus;
  cmd_out_type cmd_out;
  logic cmd_valid;
  logic order_error;
  int n_fail = 0;
  int comparisons = 0;
  // Single commands: first half, second half, opcode, bank
  logic [5:0] f[5] = '{{1'b0, `OPC_PRECHARGE}, {1'b1, `OPC_PRECHARGE}, {1'b0, `OPC_REFRESH},
    {1'b0, `OPC_SREF_ENTRY}, {1'b0, `OPC_SREF_EXIT}};
  logic [5:0] s[5] = '{6'h05, 6'h05, 6'h03, 6'h00, 6'h00};
  op_type o[5] = '{op_precharge, op_precharge, op_refresh, op_sref_entry, op_sref_exit};
  logic [2:0] bk[3] = '{3'h5, 3'h0, 3'h3};
  // Clock
  always #5 core_clk = ~core_clk;
  cmd_ctrl_model ctrl (.core_clk(core_clk), .bus_out(bus));
  dram_two_cycle_command_decoder dut (.core_clk(core_clk), .rst(rst), .bus_in(bus),
    .burst_on_the_fly(burst_on_the_fly), .cmd_out_ff(cmd_out), .cmd_valid_ff(cmd_valid),
    .order_error_ff(order_error));
  // Compare and count
  task automatic chk(string nm, logic [16:0] e, logic [16:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Queue a whole pair so it never splits
  task automatic cmd(logic [5:0] a, logic [5:0] b);
    ctrl.q.push_back({1'b1, a});
    ctrl.q.push_back({1'b0, b});
  endtask : cmd
  // Bounded wait for a decode; trailing idle gives at least three deselects
  task automatic took(op_type op);
    int i;
    for (i = 0; i < 12 && cmd_valid !== 1'b1; i++)
      @(negedge core_clk);
    chk("valid", 17'h1, 17'(cmd_valid));
    if (cmd_valid !== 1'b1)
      tally_and_finish();
    else
    begin
      chk("op", 17'(op), 17'(cmd_out.op));
      repeat (3) @(negedge core_clk);
    end
  endtask : took
  // Reset for 20 cycles
  task automatic reset_dut;
    @(negedge core_clk);
    rst = 1'b1;
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
  endtask : reset_dut
  // Watch a window; no decode allowed, error expected
  task automatic refused;
    logic v;
    v = 1'b0;
    repeat (6)
    begin
      @(negedge core_clk);
      v = v | cmd_valid;
    end
    chk("no_valid", 17'h0, 17'(v));
    chk("order_error", 17'h1, 17'(order_error));
  endtask : refused
  // Main sequence
  initial
  begin
    reset_dut();
    for (int i = 0; i < 5; i++)
    begin
      cmd(f[i], s[i]);
      took(o[i]);
      if (i < 3)
      begin
        chk("bank", 17'(bk[i]), 17'(cmd_out.bank));
        chk("all_banks", 17'(f[i][5]), 17'(cmd_out.all_banks_flag));
      end
    end
    $display("test singles done");
    burst_on_the_fly = 1'b1;
    cmd({1'b1, `OPC_READ}, 6'h36);
    cmd({1'b0, `OPC_COLUMN_SECOND}, 6'h2d);
    took(op_read);
    chk("burst", 17'(`BURST_LONG), 17'(cmd_out.burst_len_select));
    chk("auto_close", 17'h1, 17'(cmd_out.auto_close_flag));
    chk("column", 17'({2'b10, 6'h2d, 2'b00}), 17'(cmd_out.column));
    cmd({1'b0, `OPC_MASKED_WRITE}, 6'h21);
    cmd({1'b0, `OPC_COLUMN_SECOND}, 6'h00);
    took(op_masked_write);
    chk("burst", 17'(`BURST_SHORT), 17'(cmd_out.burst_len_select));
    burst_on_the_fly = 1'b0;
    cmd({1'b1, `OPC_WRITE}, 6'h02);
    cmd({1'b1, `OPC_COLUMN_SECOND}, 6'h2c);
    took(op_write);
    chk("burst", 17'(`BURST_SHORT), 17'(cmd_out.burst_len_select));
    chk("column", 17'({2'b01, 6'h2c, 2'b00}), 17'(cmd_out.column));
    chk("bank", 17'h2, 17'(cmd_out.bank));
    $display("test accesses done");
    cmd({1'b1, `OPC_MRW_FIRST}, 6'h0b);
    cmd({1'b0, `OPC_MRW_SECOND}, 6'h15);
    took(op_mrw);
    chk("mode_addr", 17'h0b, 17'(cmd_out.mode_addr));
    chk("operand", 17'h95, 17'(cmd_out.operand));
    cmd({1'b0, `OPC_MRR_FIRST}, 6'h07);
    cmd({1'b0, `OPC_COLUMN_SECOND}, 6'h01);
    took(op_mrr);
    chk("mode_addr", 17'h07, 17'(cmd_out.mode_addr));
    cmd(6'h29, 6'h23);
    cmd(6'h17, 6'h2c);
    took(op_activate);
    chk("row", {1'b0, 4'ha, 2'b10, 4'h5, 6'h2c}, cmd_out.row);
    chk("bank", 17'h3, 17'(cmd_out.bank));
    cmd(6'h00, 6'h25);
    took(op_multi);
    chk("operand", 17'h25, 17'(cmd_out.operand[6:0]));
    cmd(6'h00, 6'h07);
    cmd({1'b0, `OPC_COLUMN_SECOND}, 6'h05);
    took(op_multi);
    chk("operand", 17'h07, 17'(cmd_out.operand[6:0]));
    chk("column", 17'({1'b0, 6'h05, 2'b00}), 17'(cmd_out.column[8:0]));
    $display("test mode and row done");
    cmd(6'h1c, 6'h00);
    refused();
    reset_dut();
    chk("order_error", 17'h0, 17'(order_error));
    ctrl.q.push_back({1'b1, 1'b0, `OPC_WRITE});
    refused();
    reset_dut();
    cmd(6'h29, 6'h23);
    cmd(6'h29, 6'h23);
    refused();
    reset_dut();
    cmd(6'h00, 6'h25);
    cmd({1'b0, `OPC_PRECHARGE}, 6'h00);
    repeat (6) @(negedge core_clk);
    chk("order_error", 17'h1, 17'(order_error));
    $display("test refusals done");
    tally_and_finish();
  end
endmodule : dram_two_cycle_command_decoder_test

// *** src/cmd_decoder_pkg.sv ***
/*
  Types shared by the command decoder.
  Assumes the constants header is included by the modules.
*/
package cmd_decoder_pkg;
  typedef enum logic [3:0]
  {
    op_none = 4'h0,
    op_multi = 4'h1,
    op_precharge = 4'h2,
    op_refresh = 4'h3,
    op_sref_entry = 4'h4,
    op_sref_exit = 4'h5,
    op_write = 4'h6,
    op_masked_write = 4'h7,
    op_read = 4'h8,
    op_mrw = 4'h9,
    op_mrr = 4'ha,
    op_activate = 4'hb,
    op_illegal = 4'hf
  } op_type;

  typedef struct packed
  {
    logic cs;
    logic [5:0] cmd_addr_lines;
  } cmd_bus_type;

  typedef struct packed
  {
    op_type op;
    logic [2:0] bank;
    logic all_banks_flag;
    logic auto_close_flag;
    logic [5:0] burst_len_select;
    logic [16:0] row;
    logic [9:0] column;
    logic [5:0] mode_addr;
    logic [7:0] operand;
  } cmd_out_type;
endpackage : cmd_decoder_pkg

// *** src/cmd_decoder_regs.svh ***
`ifndef CMD_DECODER_REGS_SVH
`define CMD_DECODER_REGS_SVH
// Burst lengths in beats
`define BURST_SHORT 6'h10
`define BURST_LONG 6'h20
// First-cycle opcode on lines 4..0
`define OPC_MULTI 5'h00
`define OPC_PRECHARGE 5'h10
`define OPC_REFRESH 5'h08
`define OPC_SREF_ENTRY 5'h18
`define OPC_WRITE 5'h04
`define OPC_SREF_EXIT 5'h14
`define OPC_MASKED_WRITE 5'h0c
`define OPC_READ 5'h02
`define OPC_COLUMN_SECOND 5'h12
`define OPC_MRW_FIRST 5'h06
`define OPC_MRW_SECOND 5'h16
`define OPC_MRR_FIRST 5'h0e
// Multipurpose operand codes that open a column pair
`define MPC_WRITE_FIFO 7'h07
`define MPC_READ_FIFO 7'h41
`define MPC_READ_CAL 7'h43
`endif

// *** src/dram_two_cycle_command_decoder.sv ***
/*
  Command bus decoder: chip select plus six command lines, two-cycle commands.
  Assumes the bus is synchronous to core_clk and the controller keeps ordering.
*/
// Operation
// - Commands two cycles, deselect one cycle
// - Don't-care bits ignored by decoder
// - Bank taken from second-cycle lines
// - All-bank bit overrides bank address
// - Auto-precharge bit flagged on accesses
// - Burst bit selects 32 or 16
// - Two lowest column bits read zero
// - Multipurpose encoding decoded
// - Precharge encoding decoded
// - Refresh encoding decoded
// - Column second-half encoding decoded
`timescale 1ns/10ps
`include "cmd_decoder_regs.svh"
module dram_two_cycle_command_decoder
(
  input wire logic core_clk,
  input wire logic rst,
  input cmd_decoder_pkg::cmd_bus_type bus_in,
  input wire logic burst_on_the_fly,
  output cmd_decoder_pkg::cmd_out_type cmd_out_ff,
  output logic cmd_valid_ff,
  output logic order_error_ff
);
  import cmd_decoder_pkg::*;

  typedef enum logic [1:0]
  {
    st_idle = 2'b00,
    st_second = 2'b01
  } state_type;

  // What the pending first half expects next
  typedef enum logic [2:0]
  {
    want_none = 3'h0,
    want_column = 3'h1,
    want_act2 = 3'h2,
    want_mrw2 = 3'h3,
    want_quiet = 3'h4
  } pend_type;

  state_type state_ff, nxt_state;
  pend_type pend_ff, nxt_pend;
  logic [1:0] quiet_ff, nxt_quiet; // Deselects still owed
  logic [5:0] first_bits; // Lines captured in first cycle
  logic first_load;
  cmd_out_type nxt_cmd_out;
  cmd_out_type acc_ff, nxt_acc; // Access awaiting column half
  logic nxt_cmd_valid, nxt_order_error;
  logic [4:0] opc;
  logic [6:0] mpc_op;

  // First half storage lives in the small latch module
  half_latch u_first
  (
    .core_clk(core_clk),
    .rst(rst),
    .load(first_load),
    .d(bus_in.cmd_addr_lines),
    .q(first_bits)
  );

  assign opc = {first_bits[4], first_bits[3], first_bits[2], first_bits[1], first_bits[0]};
  assign mpc_op = {first_bits[5], bus_in.cmd_addr_lines};

  // Next-state decode; cmd lines are only looked at when cs or phase says so
  always_comb
  begin
    nxt_state = state_ff;
    nxt_pend = pend_ff;
    nxt_quiet = quiet_ff;
    nxt_cmd_out = cmd_out_ff;
    nxt_acc = acc_ff;
    nxt_cmd_valid = 1'b0;
    nxt_order_error = order_error_ff;
    first_load = 1'b0;
    unique case (state_ff)
      st_idle:
      begin
        if (bus_in.cs)
        begin
          first_load = 1'b1;
          nxt_state = st_second;
          // Owed deselects not honoured
          if (quiet_ff != 2'h0)
            nxt_order_error = 1'b1;
        end
        else
        begin
          // Deselect: lines are don't-care; counts down owed quiet cycles
          if (quiet_ff != 2'h0)
            nxt_quiet = quiet_ff - 2'h1;
          // A pending pair broken by deselect is an ordering fault
          if (pend_ff != want_none && pend_ff != want_quiet)
          begin
            nxt_order_error = 1'b1;
            nxt_pend = want_none;
          end
        end
      end
      st_second:
      begin
        // Second cycle: cs expected low; cs high here sits outside the table
        nxt_state = st_idle;
        if (bus_in.cs)
          nxt_order_error = 1'b1;
        nxt_cmd_out = cmd_out_ff;
        nxt_cmd_out.op = op_none;
        if (first_bits[0] && !first_bits[1])
        begin
          // Activate-1
          if (pend_ff != want_none)
            nxt_order_error = 1'b1;
          nxt_acc.row[16:10] = 7'h00;
          nxt_acc.row[15:12] = first_bits[5:2];
          nxt_acc.row[11:10] = bus_in.cmd_addr_lines[5:4];
          nxt_acc.bank = bus_in.cmd_addr_lines[2:0];
          nxt_pend = want_act2;
        end
        else if (first_bits[0] && first_bits[1])
        begin
          // Activate-2 completes row
          if (pend_ff != want_act2)
            nxt_order_error = 1'b1;
          else
          begin
            nxt_cmd_out = acc_ff;
            nxt_cmd_out.op = op_activate;
            nxt_cmd_out.row[9:0] = {first_bits[5:2], bus_in.cmd_addr_lines};
            nxt_cmd_valid = 1'b1;
          end
          nxt_pend = want_none;
        end
        else
        begin
          if (pend_ff == want_act2 || pend_ff == want_mrw2)
            if (opc != `OPC_MRW_SECOND || pend_ff != want_mrw2)
              nxt_order_error = 1'b1;
          if (pend_ff == want_column && opc != `OPC_COLUMN_SECOND)
            nxt_order_error = 1'b1;
          nxt_pend = want_none;
          case (opc)
            `OPC_MULTI:
            begin
              nxt_cmd_out.op = op_multi;
              nxt_cmd_out.operand = {1'b0, mpc_op};
              nxt_cmd_valid = 1'b1;
              if (mpc_op == `MPC_WRITE_FIFO || mpc_op == `MPC_READ_FIFO ||
                  mpc_op == `MPC_READ_CAL)
              begin
                nxt_pend = want_column;
                nxt_acc = nxt_cmd_out;
                nxt_cmd_valid = 1'b0;
              end
              else
                nxt_quiet = 2'h2;
            end
            `OPC_PRECHARGE, `OPC_REFRESH:
            begin
              nxt_cmd_out.op = (opc == `OPC_PRECHARGE) ? op_precharge : op_refresh;
              nxt_cmd_out.all_banks_flag = first_bits[5];
              // All-bank: bank address is ignored
              nxt_cmd_out.bank = first_bits[5] ? 3'h0 : bus_in.cmd_addr_lines[2:0];
              nxt_cmd_valid = 1'b1;
            end
            `OPC_SREF_ENTRY, `OPC_SREF_EXIT:
            begin
              nxt_cmd_out.op = (opc == `OPC_SREF_ENTRY) ? op_sref_entry : op_sref_exit;
              nxt_cmd_valid = 1'b1;
            end
            `OPC_WRITE, `OPC_MASKED_WRITE, `OPC_READ:
            begin
              nxt_acc = cmd_out_ff;
              nxt_acc.op = (opc == `OPC_WRITE) ? op_write :
                           (opc == `OPC_READ) ? op_read : op_masked_write;
              nxt_acc.bank = bus_in.cmd_addr_lines[2:0];
              nxt_acc.auto_close_flag = bus_in.cmd_addr_lines[5];
              nxt_acc.column = 10'h000;
              nxt_acc.column[9] = bus_in.cmd_addr_lines[4];
              // Masked write is fixed at 16; line five is only a burst bit elsewhere
              if (opc != `OPC_MASKED_WRITE && burst_on_the_fly && first_bits[5])
                nxt_acc.burst_len_select = `BURST_LONG;
              else
                nxt_acc.burst_len_select = `BURST_SHORT;
              nxt_pend = want_column;
            end
            `OPC_MRR_FIRST:
            begin
              nxt_acc = cmd_out_ff;
              nxt_acc.op = op_mrr;
              nxt_acc.mode_addr = bus_in.cmd_addr_lines;
              nxt_pend = want_column;
            end
            `OPC_MRW_FIRST:
            begin
              nxt_acc = cmd_out_ff;
              nxt_acc.op = op_mrw;
              nxt_acc.mode_addr = bus_in.cmd_addr_lines;
              nxt_acc.operand = {first_bits[5], 7'h00};
              nxt_pend = want_mrw2;
            end
            `OPC_MRW_SECOND:
            begin
              if (pend_ff == want_mrw2)
              begin
                nxt_cmd_out = acc_ff;
                nxt_cmd_out.operand[6:0] = {first_bits[5], bus_in.cmd_addr_lines};
                nxt_cmd_valid = 1'b1;
              end
            end
            `OPC_COLUMN_SECOND:
            begin
              if (pend_ff != want_column)
                nxt_order_error = 1'b1;
              else
              begin
                nxt_cmd_out = acc_ff;
                // Low two column bits never sent
                nxt_cmd_out.column[8:0] = {first_bits[5], bus_in.cmd_addr_lines, 2'b00};
                nxt_cmd_valid = 1'b1;
              end
            end
            default:
            begin
              // Reserved encodings mark the op illegal and raise the fault flag, with no valid
              nxt_cmd_out.op = op_illegal;
              nxt_order_error = 1'b1;
            end
          endcase
        end
      end
      default:
      begin
        nxt_state = st_idle;
      end
    endcase
  end

  // Register everything; fault flag sticks until reset (reinit)
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= st_idle;
      pend_ff <= want_none;
      quiet_ff <= 2'h0;
      cmd_out_ff <= '0;
      acc_ff <= '0;
      cmd_valid_ff <= 1'b0;
      order_error_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      quiet_ff <= nxt_quiet;
      cmd_out_ff <= nxt_cmd_out;
      acc_ff <= nxt_acc;
      cmd_valid_ff <= nxt_cmd_valid;
      order_error_ff <= nxt_order_error;
    end
  end
endmodule : dram_two_cycle_command_decoder

// *** src/half_latch.sv ***
/*
  Holds the first half of a two-cycle command.
  Assumes a synchronous load strobe.
*/
`timescale 1ns/10ps
module half_latch
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [5:0] d,
  output logic [5:0] q
);
  logic [5:0] nxt_q;
  // Next value
  always_comb
  begin
    nxt_q = load ? d : q;
  end
  // Store
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q <= 6'h00;
    else
      q <= nxt_q;
  end
endmodule : half_latch
